// >>> core/ssf_fifo.sv
`timescale 1ns/1ps
module ssf_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [AW:0] count,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full = (cnt_r == (AW+1)'(D));
  assign empty = (cnt_r == '0);
  assign count = cnt_r;
  assign rdata = mem_r[rptr_r];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge ref_clk)
  begin
    if (do_push)
    begin
      mem_r[wptr_r] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wptr_r <= (wptr_r == AW'(D-1)) ? '0 : wptr_r + 1'b1;
      end
      if (do_pop)
      begin
        rptr_r <= (rptr_r == AW'(D-1)) ? '0 : rptr_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// >>> core/ssf_pkg.sv
package ssf_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] PRESCALE_OFS = 8'h10;
  localparam logic [7:0] RAW_FLAG_OFS = 8'h14;
  localparam logic [7:0] INT_CLEAR_OFS = 8'h18;
  localparam logic [7:0] DMA_CTRL_OFS = 8'h1c;
  // control_reg_zero fields
  localparam int C0_WSIZE_LSB = 0;
  localparam int C0_FMT_LSB = 4;
  localparam int C0_POL_BIT = 6;
  localparam int C0_PHA_BIT = 7;
  localparam int C0_RATE_LSB = 8;
  localparam logic [1:0] FMT_FOUR_WIRE = 2'h0;
  localparam logic [1:0] FMT_FRAMED_SYNC = 2'h1;
  // control_reg_one fields
  localparam int C1_PORT_ENABLE_BIT = 1;
  // interrupt_clear_reg and raw flag fields
  localparam int ICR_OVERRUN_CLEAR_BIT = 0;
  localparam int ICR_TIMEOUT_CLEAR_BIT = 1;
  localparam int FLG_OVERRUN_BIT = 0;
  localparam int FLG_TIMEOUT_BIT = 1;
  localparam int FLG_RX_LEVEL_BIT = 2;
  localparam int FLG_TX_LEVEL_BIT = 3;
  // dma_control_reg fields
  localparam int DMA_RX_EN_BIT = 0;
  localparam int DMA_TX_EN_BIT = 1;
  // Reset values
  localparam logic [15:0] CTRL0_RST = 16'h0007;
  localparam logic [7:0] PRESCALE_RST = 8'h02;
  localparam logic [1:0] DMA_CTRL_RST = 2'h0;
  // Queue geometry and watermarks
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] WATERMARK = 4'h4;
  localparam logic [3:0] MIN_WSIZE = 4'h3;
  // Idle time before receive time-out, in bit periods and half periods
  localparam int TIMEOUT_BITS = 32;
  localparam logic [6:0] TIMEOUT_HALVES = 7'(2 * TIMEOUT_BITS);
endpackage

// >>> core/ssf_port.sv
// Summary of operation
// - Overrun flag on word arriving at full queue
// - Overflowing and later words are discarded
// - Word stored if space freed before completion
// - Time-out after 32 idle bit periods
// - Receive DMA request at half full
// - Transmit DMA request at half empty
// - DMA request held until clear input
// - DMA requests drop when disabled
// - Bursts of four, none for remainder
// - Start when enabled with queued data
// - Transmit flag when four or fewer queued
// - Word length 4 to 16, MSB first
// - Frame select shape per format
// - Framed sync idle and one-bit pulse
// - Framed sync sample falling, store after
// - Four-wire polarity sets idle, phase sets capture
// - Four-wire idle levels and start timing
// - Four-wire frame select high between words
// - Overrun clear bit clears flag
// - Bit clock from prescale and rate factor
`timescale 1ns/1ps
module ssf_port (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic serial_bit_clock,
  output logic frame_select_line,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic serial_data_in,
  output logic dma_rx_burst_request,
  output logic dma_tx_burst_request,
  input wire logic dma_rx_clear,
  input wire logic dma_tx_clear,
  output logic overrun_flag,
  output logic timeout_flag,
  output logic rx_level_flag,
  output logic tx_level_flag,
  output logic combined_port_interrupt
);
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_BITS, ST_TRAIL, ST_GAP} ssf_state_e;

  localparam int AW = ssf_pkg::FIFO_AW;
  localparam int W = ssf_pkg::FIFO_WIDTH;

  logic [15:0] ctrl0_r;
  logic enable_r;
  logic [7:0] prescale_r;
  logic [1:0] dma_ctrl_r;
  logic [31:0] rdata_r;
  logic ovr_r;
  logic tmo_r;
  logic dma_rx_r;
  logic dma_tx_r;
  logic sdi_s1_r;
  logic sdi_s2_r;
  logic [6:0] pre_cnt_r;
  logic [7:0] rate_cnt_r;
  logic [6:0] to_cnt_r;
  ssf_state_e state_r;
  logic [4:0] cnt_r;
  logic [15:0] tx_sh_r;
  logic [15:0] rx_sh_r;
  logic sdo_r;
  logic sclk_r;
  logic push_pend_r;

  logic wr_hit_data;
  logic rd_hit_data;
  logic wr_icr;
  logic tx_full;
  logic tx_empty;
  logic [AW:0] tx_count;
  logic [W-1:0] tx_rdata;
  logic tx_pop;
  logic rx_full;
  logic rx_empty;
  logic [AW:0] rx_count;
  logic [W-1:0] rx_rdata;
  logic rx_push;
  logic [15:0] rx_word;
  logic [3:0] wsz;
  logic [1:0] fmt;
  logic is_ssi;
  logic pol;
  logic late_cap;
  logic [7:0] rate;
  logic [6:0] half_pre;
  logic pre_tick;
  logic half_tick;
  logic [4:0] last_edge;
  logic edge_lead;
  logic drive_ev;
  logic capture_ev;
  logic start_ev;
  logic busy;
  logic rx_cond;
  logic tx_cond;

  assign wr_hit_data = reg_wr && (reg_addr == ssf_pkg::DATA_OFS);
  assign rd_hit_data = reg_rd && (reg_addr == ssf_pkg::DATA_OFS);
  assign wr_icr = reg_wr && (reg_addr == ssf_pkg::INT_CLEAR_OFS);
  assign fmt = ctrl0_r[ssf_pkg::C0_FMT_LSB +: 2];
  assign is_ssi = (fmt == ssf_pkg::FMT_FRAMED_SYNC);
  assign pol = ctrl0_r[ssf_pkg::C0_POL_BIT] && !is_ssi;
  // phase one and framed sync capture late
  assign late_cap = ctrl0_r[ssf_pkg::C0_PHA_BIT] || is_ssi;
  assign rate = ctrl0_r[ssf_pkg::C0_RATE_LSB +: 8];
  // word size clamped to 4..16 bits
  assign wsz = (ctrl0_r[3:0] < ssf_pkg::MIN_WSIZE) ? ssf_pkg::MIN_WSIZE : ctrl0_r[3:0];
  assign last_edge = {wsz, 1'b1};
  assign busy = (state_r != ST_IDLE);

  ssf_fifo #(.W(W), .D(ssf_pkg::FIFO_DEPTH), .AW(AW)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(wr_hit_data),
    .wdata(reg_wdata[W-1:0]),
    .pop(tx_pop),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count),
    .rdata(tx_rdata)
  );

  ssf_fifo #(.W(W), .D(ssf_pkg::FIFO_DEPTH), .AW(AW)) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(rx_push),
    .wdata(rx_word),
    .pop(rd_hit_data),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count),
    .rdata(rx_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl0_r <= ssf_pkg::CTRL0_RST;
      enable_r <= 1'b0;
      prescale_r <= ssf_pkg::PRESCALE_RST;
      dma_ctrl_r <= ssf_pkg::DMA_CTRL_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ssf_pkg::CTRL0_OFS: ctrl0_r <= reg_wdata[15:0];
        ssf_pkg::CTRL1_OFS: enable_r <= reg_wdata[ssf_pkg::C1_PORT_ENABLE_BIT];
        ssf_pkg::PRESCALE_OFS: prescale_r <= {reg_wdata[7:1], 1'b0};
        ssf_pkg::DMA_CTRL_OFS: dma_ctrl_r <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_r <= '0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        ssf_pkg::CTRL0_OFS: rdata_r <= {16'h0000, ctrl0_r};
        ssf_pkg::CTRL1_OFS: rdata_r <= {30'h0, enable_r, 1'b0};
        ssf_pkg::DATA_OFS: rdata_r <= rx_empty ? '0 : {16'h0000, rx_rdata};
        ssf_pkg::STATUS_OFS: rdata_r <= {27'h0, busy, rx_full, !rx_empty, !tx_full, tx_empty};
        ssf_pkg::PRESCALE_OFS: rdata_r <= {24'h0, prescale_r};
        ssf_pkg::RAW_FLAG_OFS: rdata_r <= {28'h0, tx_level_flag, rx_level_flag, tmo_r, ovr_r};
        ssf_pkg::DMA_CTRL_OFS: rdata_r <= {30'h0, dma_ctrl_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate generator: one pulse per half bit period
  // even prescale then rate factor plus one
  assign half_pre = (prescale_r[7:1] == 7'h00) ? 7'h01 : prescale_r[7:1];
  assign pre_tick = (pre_cnt_r >= 7'(half_pre - 7'h01));
  assign half_tick = pre_tick && (rate_cnt_r >= rate);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_cnt_r <= '0;
      rate_cnt_r <= '0;
    end
    else
    begin
      pre_cnt_r <= pre_tick ? '0 : pre_cnt_r + 7'h01;
      if (pre_tick)
      begin
        rate_cnt_r <= half_tick ? '0 : rate_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end
    else
    begin
      sdi_s1_r <= serial_data_in;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine
  // start on enable with queued data
  assign start_ev = (state_r == ST_IDLE) && enable_r && !tx_empty && half_tick;
  assign tx_pop = start_ev;
  assign edge_lead = !cnt_r[0];
  assign capture_ev = (state_r == ST_BITS) && half_tick && (late_cap ? !edge_lead : edge_lead);
  // early phase drives data half period after select drops
  assign drive_ev = half_tick && ((state_r == ST_BITS && (late_cap ? edge_lead : !edge_lead)
                    && cnt_r != last_edge) || (state_r == ST_LEAD && !late_cap && cnt_r == 5'h00));

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else if (!enable_r)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else if (start_ev)
    begin
      state_r <= ST_LEAD;
      cnt_r <= '0;
    end
    else if (half_tick)
    begin
      case (state_r)
        ST_LEAD:
        begin
          cnt_r <= cnt_r + 5'h01;
          // four-wire first clock edge comes one bit period after select drops
          if (cnt_r == 5'h01 || !is_ssi)
          begin
            state_r <= ST_BITS;
            cnt_r <= '0;
          end
        end
        ST_BITS:
        begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == last_edge)
          begin
            // framed sync stores and may restart on next rising edge
            state_r <= is_ssi ? ST_IDLE : ST_TRAIL;
            cnt_r <= '0;
          end
        end
        ST_TRAIL:
        begin
          cnt_r <= cnt_r + 5'h01;
          // select stays low one bit after last clock edge
          if (cnt_r == 5'h01)
          begin
            state_r <= ST_GAP;
          end
        end
        ST_GAP: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_sh_r <= '0;
      sdo_r <= 1'b0;
    end
    else if (start_ev)
    begin
      tx_sh_r <= tx_rdata << (4'hf - wsz);
    end
    else if (drive_ev)
    begin
      sdo_r <= tx_sh_r[15];
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
    end
    else if (state_r == ST_IDLE)
    begin
      sdo_r <= 1'b0;
    end
  end

  // framed sync clock idles low and runs during the pulse
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_r <= 1'b0;
    end
    else if (half_tick && (state_r == ST_BITS || (state_r == ST_LEAD && is_ssi)))
    begin
      sclk_r <= !sclk_r;
    end
    else if (state_r == ST_IDLE || state_r == ST_GAP)
    begin
      sclk_r <= pol;
    end
  end

  // shift in on capture edges, store after last bit
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sh_r <= '0;
      push_pend_r <= 1'b0;
    end
    else
    begin
      if (capture_ev)
      begin
        rx_sh_r <= {rx_sh_r[14:0], sdi_s2_r};
      end
      push_pend_r <= (state_r == ST_BITS) && half_tick && (cnt_r == last_edge) && enable_r;
    end
  end

  assign rx_word = rx_sh_r & (16'hffff >> (4'hf - wsz));
  // discard at full queue or while overrun stands
  // space freed before completion keeps the word
  assign rx_push = push_pend_r && !rx_full && !ovr_r;

  // select low for four-wire frame, pulse high before framed sync word
  assign frame_select_line = is_ssi ? (state_r == ST_LEAD)
                             : (state_r == ST_IDLE || state_r == ST_GAP);
  assign serial_bit_clock = sclk_r;
  assign serial_data_out = sdo_r;
  // framed sync data line released outside the word
  assign serial_data_out_oe = enable_r && (!is_ssi || state_r == ST_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // Event flags
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovr_r <= 1'b0;
    end
    // word completing at full queue sets overrun
    else if (push_pend_r && rx_full)
    begin
      ovr_r <= 1'b1;
    end
    else if (wr_icr && reg_wdata[ssf_pkg::ICR_OVERRUN_CLEAR_BIT])
    begin
      ovr_r <= 1'b0;
    end
  end

  // count idle half periods with unread data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      to_cnt_r <= '0;
    end
    else if (rx_empty || rd_hit_data || busy || !enable_r)
    begin
      to_cnt_r <= '0;
    end
    else if (half_tick && to_cnt_r != ssf_pkg::TIMEOUT_HALVES)
    begin
      to_cnt_r <= to_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tmo_r <= 1'b0;
    end
    else if (to_cnt_r == ssf_pkg::TIMEOUT_HALVES)
    begin
      tmo_r <= 1'b1;
    end
    else if ((wr_icr && reg_wdata[ssf_pkg::ICR_TIMEOUT_CLEAR_BIT]) || (start_ev && !rx_full))
    begin
      tmo_r <= 1'b0;
    end
  end

  assign overrun_flag = ovr_r;
  assign timeout_flag = tmo_r;
  assign rx_level_flag = (rx_count >= (AW+1)'(ssf_pkg::WATERMARK));
  // transmit flag at four or fewer, or disabled
  assign tx_level_flag = !enable_r || (tx_count <= (AW+1)'(ssf_pkg::WATERMARK));
  assign combined_port_interrupt = ovr_r || tmo_r || rx_level_flag || tx_level_flag;

  ////////////////////////////////////////////////////////////////////////////
  // DMA requests
  // receive request at half full
  // burst of four filled, none for three
  assign rx_cond = (rx_count >= (AW+1)'(ssf_pkg::WATERMARK));
  // transmit request at four empty locations
  assign tx_cond = (tx_count <= (AW+1)'(ssf_pkg::WATERMARK));

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dma_rx_r <= 1'b0;
      dma_tx_r <= 1'b0;
    end
    else
    begin
      // disabled port or enable bit drops request
      // held until the matching clear input
      if (!enable_r || !dma_ctrl_r[ssf_pkg::DMA_RX_EN_BIT] || dma_rx_clear)
      begin
        dma_rx_r <= 1'b0;
      end
      else if (rx_cond)
      begin
        dma_rx_r <= 1'b1;
      end
      if (!enable_r || !dma_ctrl_r[ssf_pkg::DMA_TX_EN_BIT] || dma_tx_clear)
      begin
        dma_tx_r <= 1'b0;
      end
      else if (tx_cond)
      begin
        dma_tx_r <= 1'b1;
      end
    end
  end

  assign dma_rx_burst_request = dma_rx_r;
  assign dma_tx_burst_request = dma_tx_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_overrun_on_full: assert property (@(posedge ref_clk) disable iff (!rst_b)
    push_pend_r && rx_full |=> ovr_r)
    else $error("overrun not raised on full queue");
  a_discard_words: assert property (@(posedge ref_clk) disable iff (!rst_b)
    push_pend_r && (rx_full || ovr_r) && !rd_hit_data |=> $stable(rx_count))
    else $error("discarded word reached receive queue");
  a_store_freed: assert property (@(posedge ref_clk) disable iff (!rst_b)
    push_pend_r && !rx_full && !ovr_r && !rd_hit_data |=> rx_count == $past(rx_count) + 1'b1)
    else $error("word lost despite free space");
  a_overrun_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_icr && reg_wdata[0] && !(push_pend_r && rx_full) |=> !ovr_r)
    else $error("overrun not cleared");
  a_timeout_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    to_cnt_r == 7'h3f && half_tick && !rx_empty && !busy && !rd_hit_data && enable_r
    |=> ##1 tmo_r)
    else $error("time-out not raised after idle period");
  a_rx_dma_req: assert property (@(posedge ref_clk) disable iff (!rst_b)
    enable_r && dma_ctrl_r[0] && rx_cond && !dma_rx_clear |=> dma_rx_burst_request)
    else $error("receive request missing");
  a_tx_dma_req: assert property (@(posedge ref_clk) disable iff (!rst_b)
    enable_r && dma_ctrl_r[1] && tx_cond && !dma_tx_clear |=> dma_tx_burst_request)
    else $error("transmit request missing");
  a_dma_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dma_rx_r && enable_r && dma_ctrl_r[0] && !dma_rx_clear |=> dma_rx_r)
    else $error("receive request dropped before clear");
  a_dma_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !enable_r |=> !dma_rx_burst_request && !dma_tx_burst_request)
    else $error("request while disabled");
  a_start_frame: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start_ev |=> state_r == ST_LEAD ##0 (frame_select_line == is_ssi))
    else $error("frame did not start");
  a_word_length: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(push_pend_r) |-> $past(cnt_r) == last_edge)
    else $error("wrong edge count per word");
  a_tx_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(enable_r) && tx_count <= 4'h4 |-> tx_level_flag)
    else $error("transmit flag missing at enable");

  c_overrun: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(ovr_r));
  c_timeout: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(tmo_r));
  c_ssi_word: cover property (@(posedge ref_clk) disable iff (!rst_b) rx_push && is_ssi);
  c_rx_dma: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(dma_rx_r));
endmodule

// >>> test/ssf_peer.sv
`timescale 1ns/1ps
module ssf_peer (
  input wire logic serial_bit_clock,
  input wire logic frame_select_line,
  input wire logic serial_data_out,
  output logic serial_data_in
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] got [0:15];
  int words;
  bit armed;
  initial
  begin
    words = 0;
    armed = 1'b0;
    serial_data_in = 1'b0;
  end
  always @(posedge serial_bit_clock)
    if (!frame_select_line)
      rx_sh <= {rx_sh[6:0], serial_data_out};
  always @(negedge serial_bit_clock)
    if (!frame_select_line)
    begin
      tx_sh = {tx_sh[6:0], 1'b0};
      serial_data_in = tx_sh[7];
    end
  // Reply word differs per frame
  always @(negedge frame_select_line)
  begin
    armed = 1'b1;
    tx_sh = 8'ha0 + 8'(words);
    serial_data_in = tx_sh[7];
  end
  // Released line shows inverse of last bit
  // Select leaving reset is no frame end
  always @(posedge frame_select_line)
    if (armed)
    begin
      got[words[3:0]] = rx_sh;
      words = words + 1;
      serial_data_in = ~serial_data_in;
    end
endmodule

// >>> test/sync_serial_port_fifo_dma_tb.sv
`timescale 1ns/1ps
module sync_serial_port_fifo_dma_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_clr = 1'b0;
  logic tx_clr = 1'b0;
  logic [31:0] reg_rdata;
  logic sclk, fsel, sdo, sdo_oe, sdi, rx_req, tx_req, ovr, tmo, rx_lvl, tx_lvl, irq;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  ssf_port DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_bit_clock(sclk), .frame_select_line(fsel), .serial_data_out(sdo),
    .serial_data_out_oe(sdo_oe), .serial_data_in(sdi), .dma_rx_burst_request(rx_req),
    .dma_tx_burst_request(tx_req), .dma_rx_clear(rx_clr), .dma_tx_clear(tx_clr),
    .overrun_flag(ovr), .timeout_flag(tmo), .rx_level_flag(rx_lvl),
    .tx_level_flag(tx_lvl), .combined_port_interrupt(irq));
  ssf_peer PEER (.serial_bit_clock(sclk), .frame_select_line(fsel),
    .serial_data_out(sdo), .serial_data_in(sdi));

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 3000 && PEER.words < n; i++)
      tick();
  endtask

  function automatic logic [31:0] txw(input int i);
    return 32'(8'h3c ^ 8'(i * 17));
  endfunction

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("ctrl0", ssf_pkg::CTRL0_OFS, 32'(ssf_pkg::CTRL0_RST));
    rdchk("prescale", ssf_pkg::PRESCALE_OFS, 32'(ssf_pkg::PRESCALE_RST));
    rdchk("unmapped", 8'h20, 32'h0);
    chk("idle sel clk", 32'h2, {30'h0, fsel, sclk});
    chk("tx level off", 32'h1, 32'(tx_lvl));
  endtask

  task automatic t_stream;
    wr(ssf_pkg::CTRL0_OFS, 32'h0307);
    wr(ssf_pkg::DMA_CTRL_OFS, 32'h3);
    for (int i = 0; i < 8; i++)
      wr(ssf_pkg::DATA_OFS, txw(i));
    chk("dma disabled", 32'h0, {30'h0, rx_req, tx_req});
    wr(ssf_pkg::CTRL1_OFS, 32'h2);
    repeat (2) tick();
    chk("tx level on", 32'h0, 32'(tx_lvl));
    // Queue was full at enable: wait until the first word has left
    repeat (4) tick();
    wr(ssf_pkg::DATA_OFS, txw(8));
    wait_words(4);
    repeat (12) tick();
    chk("dma req", 32'h3, {30'h0, rx_req, tx_req});
    chk("rx level", 32'h1, 32'(rx_lvl));
    @(posedge ref_clk);
    rx_clr <= 1'b1;
    tx_clr <= 1'b1;
    repeat (2) tick();
    chk("dma cleared", 32'h0, {30'h0, rx_req, tx_req});
    @(posedge ref_clk);
    rx_clr <= 1'b0;
    tx_clr <= 1'b0;
    repeat (3) tick();
    chk("dma again", 32'h3, {30'h0, rx_req, tx_req});
    wait_words(9);
    repeat (4) tick();
    chk("overrun irq", 32'h3, {30'h0, ovr, irq});
    for (int i = 0; i < 9; i++)
      chk("peer word", txw(i), 32'(PEER.got[i]));
    rdchk("rx head", ssf_pkg::DATA_OFS, 32'ha0);
    wr(ssf_pkg::INT_CLEAR_OFS, 32'h0);
    chk("overrun kept", 32'h1, 32'(ovr));
    wr(ssf_pkg::INT_CLEAR_OFS, 32'h1);
    chk("overrun clear", 32'h0, 32'(ovr));
    repeat (200) tick();
    chk("timeout early", 32'h0, 32'(tmo));
    repeat (80) tick();
    chk("timeout", 32'h1, 32'(tmo));
    for (int i = 1; i < 8; i++)
      rdchk("rx word", ssf_pkg::DATA_OFS, 32'(8'ha0 + 8'(i)));
    rdchk("rx empty", ssf_pkg::DATA_OFS, 32'h0);
  endtask

  task automatic t_framed;
    int w;
    wr(ssf_pkg::CTRL1_OFS, 32'h0);
    tick();
    chk("dma off", 32'h0, {30'h0, rx_req, tx_req});
    wr(ssf_pkg::CTRL0_OFS, 32'h0317);
    chk("fs idle", 32'h0, {29'h0, sclk, fsel, sdo_oe});
    wr(ssf_pkg::DATA_OFS, 32'h5a);
    wr(ssf_pkg::CTRL1_OFS, 32'h2);
    for (int n = 0; n < 200 && fsel !== 1'b1; n++)
      tick();
    for (w = 0; w < 50 && fsel === 1'b1; w++)
      tick();
    chk("fs pulse", 32'd8, 32'(w));
    repeat (2) tick();
    chk("fs drive", 32'h1, 32'(sdo_oe));
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_stream();
    t_framed();
    final_report();
  end
endmodule
